// *** design/dpsc_consts.vh ***
`ifndef DPSC_CONSTS_VH
`define DPSC_CONSTS_VH
`define DPSC_ADDR_W      16
`define DPSC_DATA_W      16
`define DPSC_LANE_W      8
`define DPSC_UPPER_LSB   8
`define DPSC_LOWER_LSB   0
`define DPSC_FLAG_IDX_W  3
`define DPSC_T_SETUP_NS  20
`define DPSC_CLK_NS      4
`define DPSC_SETUP_CYC   ((`DPSC_T_SETUP_NS + `DPSC_CLK_NS - 1) / `DPSC_CLK_NS)
`define DPSC_CNT_W       4
`define DPSC_RDATA_RST   16'h0000
`endif

// *** design/dpsc_rd_hold.v ***
`timescale 1ns/10ps
`default_nettype none
`include "dpsc_consts.vh"
module dpsc_rd_hold (
   // Clock and reset
   input  wire                     clk_i,
   input  wire                     rst_b_i,
   // Capture
   input  wire                     cap_i,
   input  wire                     up_en_i,
   input  wire                     lo_en_i,
   input  wire [`DPSC_DATA_W-1:0]  d_i,
   output reg  [`DPSC_DATA_W-1:0]  q_o
);
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q_o <= `DPSC_RDATA_RST;
      end else if (cap_i) begin
         // Lanes not read come back as zero
         q_o <= {up_en_i ? d_i[15:8] : 8'h00, lo_en_i ? d_i[7:0] : 8'h00};
      end
   end
endmodule // dpsc_rd_hold
`default_nettype wire

// *** design/dpsc_host.v ***
// Behaviour
// RULE1: Each device port is independent, so this controller drives one full port of address, data and controls.
// RULE2: The port is selected only with the active-low enable low and the active-high enable high together.
// RULE3: Between accesses one enable is inactive so the port stands by and does no array access.
// RULE4: While deselected with the flag area off the device floats both data lanes, and so may this side.
// RULE5: An upper-only write drives the upper lane with upper select low and leaves the lower lane undriven.
// RULE6: A lower-only write drives the lower lane only; a word write drives both lanes.
// RULE7: An upper-only read asserts output enable and upper select and samples only the upper lane.
// RULE8: A lower-only read samples the lower lane; a word read samples both lanes.
// RULE9: The cascade role select is a steady output: high makes the device master, low slave.
// RULE10: Output enable is kept high whenever a read is not in progress, so the device floats its lanes.
// RULE11: Both byte selects stay high when idle so no array access takes place.
// RULE12: A flag access asserts the flag-area select and puts the flag index on the three lowest address bits.
`timescale 1ns/10ps
`default_nettype none
`include "dpsc_consts.vh"
module dpsc_host (
   // Clock and reset
   input  wire                     clk_i,
   input  wire                     rst_b_i,
   // User request
   input  wire                     req_i,
   input  wire                     req_write_i,
   input  wire                     req_flag_i,
   input  wire                     req_upper_i,
   input  wire                     req_lower_i,
   input  wire [`DPSC_ADDR_W-1:0]  req_addr_i,
   input  wire [`DPSC_DATA_W-1:0]  req_wdata_i,
   input  wire                     master_role_i,
   output reg                      busy_o,
   output reg                      done_o,
   output wire [`DPSC_DATA_W-1:0]  rdata_o,
   // Device port pins
   output reg                      chip_enable_low_active_o,
   output reg                      chip_enable_high_active_o,
   output reg                      read_write_select_o,
   output reg                      out_enable_b_o,
   output reg                      flag_area_select_b_o,
   output reg                      upper_byte_select_b_o,
   output reg                      lower_byte_select_b_o,
   output reg  [`DPSC_ADDR_W-1:0]  addr_o,
   output reg  [`DPSC_DATA_W-1:0]  data_o,
   output reg                      data_up_oe_o,
   output reg                      data_lo_oe_o,
   input  wire [`DPSC_DATA_W-1:0]  data_i,
   output reg                      master_slave_o
);
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_ACC  = 2'b01;
   localparam [1:0] ST_END  = 2'b10;

   reg [1:0]             state_q;
   reg [`DPSC_CNT_W-1:0] cnt_q;
   reg                   wr_q;
   reg                   flag_q;
   reg                   up_q;
   reg                   lo_q;
   wire                  cap;
   wire [31:0]           setup_last;

   assign cap = (state_q == ST_ACC) && (cnt_q == 4'h0) && !wr_q;
   // Strobe count start, cut to the counter width
   assign setup_last = `DPSC_SETUP_CYC - 1;

   dpsc_rd_hold u_rd_hold (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .cap_i   (cap),
      .up_en_i (up_q | flag_q),
      .lo_en_i (lo_q | flag_q),
      .d_i     (data_i),
      .q_o     (rdata_o)
   );

   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q                   <= ST_IDLE;
         cnt_q                     <= 4'h0;
         wr_q                      <= 1'b0;
         flag_q                    <= 1'b0;
         up_q                      <= 1'b0;
         lo_q                      <= 1'b0;
         busy_o                    <= 1'b0;
         done_o                    <= 1'b0;
         chip_enable_low_active_o  <= 1'b1;
         chip_enable_high_active_o <= 1'b0;
         read_write_select_o       <= 1'b1;
         out_enable_b_o            <= 1'b1;
         flag_area_select_b_o      <= 1'b1;
         upper_byte_select_b_o     <= 1'b1;
         lower_byte_select_b_o     <= 1'b1;
         addr_o                    <= 16'h0000;
         data_o                    <= 16'h0000;
         data_up_oe_o              <= 1'b0;
         data_lo_oe_o              <= 1'b0;
         master_slave_o            <= 1'b0;
      end else begin
         master_slave_o <= master_role_i; // RULE9
         done_o         <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (req_i && (req_flag_i || req_upper_i || req_lower_i)) begin
                  wr_q   <= req_write_i;
                  flag_q <= req_flag_i;
                  up_q   <= req_upper_i & !req_flag_i;
                  lo_q   <= req_lower_i & !req_flag_i;
                  busy_o <= 1'b1;
                  cnt_q  <= setup_last[`DPSC_CNT_W-1:0];
                  read_write_select_o <= !req_write_i;
                  data_o <= req_wdata_i;
                  if (req_flag_i) begin
                     // Flag index on low address bits, array deselected
                     addr_o <= {13'h0000, req_addr_i[2:0]}; // RULE12
                     flag_area_select_b_o      <= 1'b0; // RULE12
                     chip_enable_low_active_o  <= 1'b1;
                     chip_enable_high_active_o <= 1'b0;
                     upper_byte_select_b_o     <= 1'b1;
                     lower_byte_select_b_o     <= 1'b1;
                     data_up_oe_o              <= req_write_i;
                     data_lo_oe_o              <= req_write_i;
                  end else begin
                     addr_o <= req_addr_i; // RULE1
                     chip_enable_low_active_o  <= 1'b0; // RULE2
                     chip_enable_high_active_o <= 1'b1; // RULE2
                     upper_byte_select_b_o     <= !req_upper_i; // RULE5 RULE7
                     lower_byte_select_b_o     <= !req_lower_i; // RULE6 RULE8
                     data_up_oe_o              <= req_write_i & req_upper_i; // RULE5 RULE6
                     data_lo_oe_o              <= req_write_i & req_lower_i; // RULE6
                  end
                  out_enable_b_o <= req_write_i; // RULE10
                  state_q <= ST_ACC;
               end
            end
            ST_ACC: begin
               if (cnt_q == 4'h0) begin
                  // Data sampled by the hold module this edge
                  state_q                   <= ST_END;
                  chip_enable_low_active_o  <= 1'b1; // RULE3
                  chip_enable_high_active_o <= 1'b0; // RULE3
                  flag_area_select_b_o      <= 1'b1;
                  upper_byte_select_b_o     <= 1'b1; // RULE11
                  lower_byte_select_b_o     <= 1'b1; // RULE11
                  out_enable_b_o            <= 1'b1; // RULE10
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            ST_END: begin
               // Release lanes and write line a cycle after the strobes
               data_up_oe_o        <= 1'b0; // RULE4
               data_lo_oe_o        <= 1'b0; // RULE4
               read_write_select_o <= 1'b1;
               busy_o              <= 1'b0;
               done_o              <= 1'b1;
               state_q             <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // dpsc_host
`default_nettype wire

// *** verification/dpsc_host_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module dpsc_host_asserts (
   // Clock, reset, user side
   input wire logic clk_i, rst_b_i, master_role_i, busy_o, done_o, master_slave_o,
   // Device pins
   input wire logic chip_enable_low_active_o, chip_enable_high_active_o, read_write_select_o, out_enable_b_o,
   input wire logic flag_area_select_b_o, upper_byte_select_b_o, lower_byte_select_b_o, data_up_oe_o, data_lo_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   chk_enable_pair: assert property (chip_enable_low_active_o == !chip_enable_high_active_o)
      else $error("chip enables split");
   chk_idle_standby: assert property (!busy_o |-> chip_enable_low_active_o && upper_byte_select_b_o
      && lower_byte_select_b_o) else $error("idle port not standing by");
   chk_oe_read_only: assert property (!out_enable_b_o |-> busy_o && read_write_select_o)
      else $error("output enable outside read");
   chk_drive_write: assert property (data_up_oe_o || data_lo_oe_o |-> !read_write_select_o)
      else $error("lane driven outside write");
   chk_upper_lane: assert property (!upper_byte_select_b_o && !read_write_select_o |-> data_up_oe_o)
      else $error("upper lane not driven");
   chk_lower_lane: assert property (!lower_byte_select_b_o && !read_write_select_o |-> data_lo_oe_o)
      else $error("lower lane not driven");
   chk_access_len: assert property ($rose(busy_o) |-> busy_o[*6] ##1 (!busy_o && done_o))
      else $error("access length wrong");
   chk_done_single: assert property (done_o |-> !busy_o ##1 !done_o) else $error("done too long");
   chk_role_copy: assert property ($stable(master_role_i)[*2] |-> master_slave_o == master_role_i)
      else $error("role not followed");
   chk_flag_desel: assert property (!flag_area_select_b_o |-> chip_enable_low_active_o && upper_byte_select_b_o
      && lower_byte_select_b_o) else $error("flag access with array selected");
   cover property ($rose(busy_o) && read_write_select_o);
   cover property (data_up_oe_o && data_lo_oe_o);
   cover property (!flag_area_select_b_o);
endmodule // dpsc_host_asserts
bind dpsc_host dpsc_host_asserts u_chk (.*);
`default_nettype wire

// *** verification/dpsc_dev_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// One port of the shared memory; the other port is not modelled
module dpsc_dev_model (
   input  wire logic        clk_i,
   // Port pins
   input  wire logic        cel_i, ceh_i, rw_i, oe_b_i, fs_b_i, upper_byte_select_b_i, lower_byte_select_b_i,
   input  wire logic [15:0] a_i,
   input  wire logic [15:0] d_i,
   output wire logic [15:0] q_o
);
   logic [15:0] mem [0:65535];
   logic [7:0]  flg;
   logic        tg = 1'h0;
   wire sel = !cel_i && ceh_i;
   wire acc = sel && fs_b_i && !(upper_byte_select_b_i && lower_byte_select_b_i);
   wire rv  = rw_i && !oe_b_i;
   // Released lanes toggle so stale data never passes
   wire [15:0] fz = {16{tg}} ^ 16'h5A5A;
   always @(posedge clk_i) tg <= ~tg;
   always @* begin
      if (acc && !rw_i && !upper_byte_select_b_i) mem[a_i][15:8] = d_i[15:8];
      if (acc && !rw_i && !lower_byte_select_b_i) mem[a_i][7:0] = d_i[7:0];
      if (!fs_b_i && !rw_i) flg[a_i[2:0]] = d_i[0];
   end
   assign q_o[15:8] = (rv && !fs_b_i) ? {8{flg[a_i[2:0]]}} :
      (rv && acc && !upper_byte_select_b_i) ? mem[a_i][15:8] : fz[15:8];
   assign q_o[7:0] = (rv && !fs_b_i) ? {8{flg[a_i[2:0]]}} :
      (rv && acc && !lower_byte_select_b_i) ? mem[a_i][7:0] : fz[7:0];
endmodule // dpsc_dev_model
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk_i=1'h0, rst_b_i=1'h0, req_i=1'h0, req_write_i=1'h0, req_flag_i=1'h0;
   logic req_upper_i=1'h0, req_lower_i=1'h0, master_role_i=1'h0;
   logic [15:0] req_addr_i=16'h0000, req_wdata_i=16'h0000;
   wire busy_o, done_o, chip_enable_low_active_o, chip_enable_high_active_o, read_write_select_o, out_enable_b_o,
      flag_area_select_b_o, upper_byte_select_b_o, lower_byte_select_b_o, data_up_oe_o, data_lo_oe_o, master_slave_o;
   wire [15:0] rdata_o, addr_o, data_o, data_i, q;
   int err_count=0, checks_done=0;
   // Shared data wire: whoever enables a lane owns it
   assign data_i = {data_up_oe_o ? data_o[15:8] : q[15:8], data_lo_oe_o ? data_o[7:0] : q[7:0]};
   dpsc_host u_dut (.*);
   dpsc_dev_model u_dev (.clk_i(clk_i), .cel_i(chip_enable_low_active_o), .ceh_i(chip_enable_high_active_o),
      .rw_i(read_write_select_o), .oe_b_i(out_enable_b_o), .fs_b_i(flag_area_select_b_o),
      .upper_byte_select_b_i(upper_byte_select_b_o), .lower_byte_select_b_i(lower_byte_select_b_o),
      .a_i(addr_o), .d_i(data_i), .q_o(q));
   initial forever #2 clk_i = ~clk_i;
   task chk(input string s, input [15:0] e, input [15:0] g); begin
      checks_done++;
      if (g !== e) begin err_count++; $display("wrong value %s expected %h seen %h", s, e, g); end
   end endtask
   task acc(input logic w, f, u, l, input [15:0] a, d); int n; begin
      @(negedge clk_i); {req_i, req_write_i, req_flag_i, req_upper_i, req_lower_i} = {1'h1, w, f, u, l};
      req_addr_i = a; req_wdata_i = d;
      @(negedge clk_i); req_i = 1'h0; n = 0;
      while (done_o !== 1'h1 && n < 20) begin @(negedge clk_i); n++; end
      if (n == 20) chk("done", 16'h0001, 16'h0000);
   end endtask
   task t_word; begin
      acc(1, 0, 1, 1, 16'hFFFF, 16'h1234); acc(0, 0, 1, 1, 16'hFFFF, 16'h0000);
      chk("word", 16'h1234, rdata_o);
   end endtask
   task t_bytes; begin
      acc(1, 0, 1, 0, 16'h0001, 16'hAB99); acc(1, 0, 0, 1, 16'h0001, 16'h77CD);
      acc(0, 0, 1, 1, 16'h0001, 16'h0000); chk("both", 16'hABCD, rdata_o);
      acc(0, 0, 1, 0, 16'h0001, 16'h0000); chk("upper", 16'hAB00, rdata_o);
      acc(0, 0, 0, 1, 16'h0001, 16'h0000); chk("lower", 16'h00CD, rdata_o);
      acc(0, 0, 1, 1, 16'hFFFF, 16'h0000); chk("word kept", 16'h1234, rdata_o);
   end endtask
   task t_reset; begin
      @(negedge clk_i); {req_i, req_write_i, req_flag_i, req_upper_i, req_lower_i} = 5'h1B;
      req_addr_i = 16'h0100;
      @(negedge clk_i); req_i = 1'h0;
      @(negedge clk_i); rst_b_i = 1'h0;
      @(negedge clk_i);
      chk("reset", 16'h0005, {12'h000, busy_o, chip_enable_low_active_o, data_up_oe_o, out_enable_b_o});
      chk("reset rdata", 16'h0000, rdata_o);
      rst_b_i = 1'h1; req_write_i = 1'h0;
      acc(0, 0, 1, 1, 16'hFFFF, 16'h0000); chk("after reset", 16'h1234, rdata_o);
   end endtask
   task t_flag; begin
      acc(1, 1, 0, 0, 16'hFFFB, 16'h0001); chk("flag addr", 16'h0003, addr_o);
      acc(0, 1, 0, 0, 16'h0003, 16'h0000);
      chk("flag set", 16'hFFFF, rdata_o);
      acc(1, 1, 0, 0, 16'h0003, 16'h0000); acc(0, 1, 0, 0, 16'h0003, 16'h0000);
      chk("flag clear", 16'h0000, rdata_o);
   end endtask
   task t_refuse; begin
      @(negedge clk_i); {req_i, req_flag_i, req_upper_i, req_lower_i} = 4'h8;
      repeat (3) @(negedge clk_i);
      chk("busy", 16'h0000, {15'h0000, busy_o});
      req_i = 1'h0;
   end endtask
   task t_role; begin
      master_role_i = 1'h1; repeat (3) @(negedge clk_i);
      chk("master", 16'h0001, {15'h0000, master_slave_o});
      master_role_i = 1'h0; repeat (3) @(negedge clk_i);
      chk("slave", 16'h0000, {15'h0000, master_slave_o});
   end endtask
   task end_sim; begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   end endtask
   initial begin
      repeat (3) @(negedge clk_i);
      rst_b_i = 1'h1;
      t_word; t_bytes; t_reset; t_flag; t_refuse; t_role;
      end_sim;
   end
   initial begin #5000; err_count++; end_sim; end
endmodule // tb_top
`default_nettype wire
